/* File: nibble_alu.sv */
// nibble logic, skip and rotate datapath with an avalon-mm register port
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - or combines two nibbles bitwise, one where either bit is one
// - and combines two nibbles bitwise, one only where both bits are one
// - xor combines two nibbles bitwise, one where the bits differ
// - register-memory form writes the register, memory-immediate form writes memory
// - bit tests act on a memory nibble with a four-bit immediate mask
// - bit tests ignore decimal mode and keep carry and zero flags
// - either bit test clears the compare-only flag
// - with index enable set, bit tests use the index-modified address
// - bits-true test skips when all masked memory bits are one
// - bits-false test skips when all masked memory bits are zero
// - skip-if-equal skips when memory equals the immediate
// - skip-if-not-equal skips when memory differs from the immediate
// - skip-if-greater-equal skips when memory is at least the immediate
// - skip-if-less skips when memory is below the immediate
// - compare skips take only memory against an immediate operand
// - compare skips ignore decimal and compare flags, keep carry and zero
// - rotate right takes only the general register as operand
// - rotate right: carry into bit 3, bits shift down, bit 0 to carry
// - rotate right changes only register and carry, ignores mode flags
// - register plus itself with carry gives a left rotate through carry
// - logical operations ignore mode flags and keep carry and zero
module nibble_alu
(
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // avalon-mm slave
  input wire logic [nibble_alu_pkg::AV_AW-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [nibble_alu_pkg::AV_DW-1:0] avs_writedata_in,
  output logic [nibble_alu_pkg::AV_DW-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // results to the sequencer
  output logic [nibble_alu_pkg::NIB_W-1:0] reg_res_out,
  output logic [nibble_alu_pkg::NIB_W-1:0] mem_res_out,
  output logic reg_wr_out,
  output logic mem_wr_out,
  output logic skip_out,
  output logic [nibble_alu_pkg::MADR_W-1:0] eaddr_out
);
  import nibble_alu_pkg::*;

  typedef struct packed {
    logic ack;
    logic wreq;
    logic [AV_DW-1:0] rdata;
    op_t op;
    logic [NIB_W-1:0] reg_v;
    logic [NIB_W-1:0] mem_v;
    logic [NIB_W-1:0] imm_v;
    logic idx_en;
    logic zf;
    logic cy;
    logic cmpf;
    logic bcd;
    logic [MADR_W-1:0] maddr;
    logic [MADR_W-1:0] ix;
    logic [NIB_W-1:0] reg_res;
    logic [NIB_W-1:0] mem_res;
    logic reg_we;
    logic mem_we;
    logic skip;
    logic supp;
    logic [MADR_W-1:0] eaddr;
  } state_t;

  state_t s_ff;
  state_t nxt_s;

  logic req;
  logic wr_hit;
  logic exec;
  logic go;
  op_t op;
  logic [MADR_W-1:0] eff;

  assign req = avs_read_in | avs_write_in;
  // a write lands only at the edge where waitrequest is seen low
  assign wr_hit = avs_write_in & s_ff.ack;
  assign exec = wr_hit & (avs_address_in == OFS_CMD);
  assign go = exec & ~s_ff.skip;
  assign op = op_t'(avs_writedata_in[NIB_W-1:0]);
  // index register ors into bank and address
  assign eff = s_ff.idx_en ? (s_ff.maddr | s_ff.ix) : s_ff.maddr;

  always_comb begin
    logic [NIB_W:0] sum;
    logic [AV_DW-1:0] rd;
    sum = {1'b0, s_ff.reg_v} + {1'b0, s_ff.reg_v} + {{NIB_W{1'b0}}, s_ff.cy};
    rd = RD_RST;
    nxt_s = s_ff;
    nxt_s.reg_we = 1'b0;
    nxt_s.mem_we = 1'b0;
    unique case (avs_address_in)
      OFS_CMD: rd = AV_DW'(s_ff.op);
      OFS_OPND: rd = AV_DW'({s_ff.imm_v, s_ff.mem_v, s_ff.reg_v});
      OFS_PSW: rd = AV_DW'({s_ff.bcd, s_ff.cmpf, s_ff.cy, s_ff.zf, s_ff.idx_en});
      OFS_ADDR: rd = {5'h00, s_ff.ix, 5'h00, s_ff.maddr};
      OFS_RES: begin
        rd = {5'h00, s_ff.eaddr, 6'h00, s_ff.supp, s_ff.skip,
              s_ff.mem_res, s_ff.reg_res};
      end
      default: rd = RD_RST;
    endcase
    // one wait cycle per access, then a single acknowledge cycle
    if (req && !s_ff.ack) begin
      nxt_s.ack = 1'b1;
      nxt_s.wreq = 1'b0;
      nxt_s.rdata = rd;
    end else begin
      nxt_s.ack = 1'b0;
      nxt_s.wreq = 1'b1;
    end
    if (wr_hit) begin
      unique case (avs_address_in)
        OFS_OPND: begin
          nxt_s.reg_v = avs_writedata_in[OPND_REG_LSB +: NIB_W];
          nxt_s.mem_v = avs_writedata_in[OPND_MEM_LSB +: NIB_W];
          nxt_s.imm_v = avs_writedata_in[OPND_IMM_LSB +: NIB_W];
        end
        OFS_PSW: begin
          nxt_s.idx_en = avs_writedata_in[PSW_IDX_EN];
          nxt_s.zf = avs_writedata_in[PSW_ZF];
          nxt_s.cy = avs_writedata_in[PSW_CY];
          nxt_s.cmpf = avs_writedata_in[PSW_CMP];
          nxt_s.bcd = avs_writedata_in[PSW_BCD];
        end
        OFS_ADDR: begin
          nxt_s.maddr = avs_writedata_in[ADDR_MEM_LSB +: MADR_W];
          nxt_s.ix = avs_writedata_in[ADDR_IX_LSB +: MADR_W];
        end
        default: ;
      endcase
    end
    if (exec && s_ff.skip) begin
      // fetched but dropped: no register, memory or flag change
      nxt_s.skip = 1'b0;
      nxt_s.supp = 1'b1;
      nxt_s.op = op;
    end else if (go) begin
      nxt_s.op = op;
      nxt_s.skip = 1'b0;
      nxt_s.supp = 1'b0;
      // memory-touching ops report their (possibly indexed) address
      if (op != OP_ROTATE_RIGHT_CARRY && op != OP_ADD_WITH_CARRY_RR) begin
        nxt_s.eaddr = eff;
      end
      // mode flags and carry/zero are left alone unless named below
      case (op)
        OP_OR_RM: begin
          nxt_s.reg_res = s_ff.reg_v | s_ff.mem_v;
          nxt_s.reg_v = s_ff.reg_v | s_ff.mem_v;
          nxt_s.reg_we = 1'b1;
        end
        OP_AND_RM: begin
          nxt_s.reg_res = s_ff.reg_v & s_ff.mem_v;
          nxt_s.reg_v = s_ff.reg_v & s_ff.mem_v;
          nxt_s.reg_we = 1'b1;
        end
        OP_XOR_RM: begin
          nxt_s.reg_res = s_ff.reg_v ^ s_ff.mem_v;
          nxt_s.reg_v = s_ff.reg_v ^ s_ff.mem_v;
          nxt_s.reg_we = 1'b1;
        end
        OP_OR_MI: begin
          nxt_s.mem_res = s_ff.mem_v | s_ff.imm_v;
          nxt_s.mem_v = s_ff.mem_v | s_ff.imm_v;
          nxt_s.mem_we = 1'b1;
        end
        OP_AND_MI: begin
          nxt_s.mem_res = s_ff.mem_v & s_ff.imm_v;
          nxt_s.mem_v = s_ff.mem_v & s_ff.imm_v;
          nxt_s.mem_we = 1'b1;
        end
        OP_XOR_MI: begin
          nxt_s.mem_res = s_ff.mem_v ^ s_ff.imm_v;
          nxt_s.mem_v = s_ff.mem_v ^ s_ff.imm_v;
          nxt_s.mem_we = 1'b1;
        end
        OP_SKIP_BITS_TRUE: begin
          // mask in the immediate, memory operand only
          nxt_s.skip = (s_ff.mem_v & s_ff.imm_v) == s_ff.imm_v;
          nxt_s.cmpf = 1'b0;
        end
        OP_SKIP_BITS_FALSE: begin
          nxt_s.skip = (s_ff.mem_v & s_ff.imm_v) == NIB_RST;
          nxt_s.cmpf = 1'b0;
        end
        OP_SKIP_EQUAL: nxt_s.skip = s_ff.mem_v == s_ff.imm_v;
        OP_SKIP_NOT_EQUAL: nxt_s.skip = s_ff.mem_v != s_ff.imm_v;
        // unsigned nibble compares
        OP_SKIP_GREATER_EQUAL: nxt_s.skip = s_ff.mem_v >= s_ff.imm_v;
        OP_SKIP_LESS: nxt_s.skip = s_ff.mem_v < s_ff.imm_v;
        OP_ROTATE_RIGHT_CARRY: begin
          nxt_s.reg_res = {s_ff.cy, s_ff.reg_v[NIB_W-1:1]};
          nxt_s.reg_v = {s_ff.cy, s_ff.reg_v[NIB_W-1:1]};
          nxt_s.cy = s_ff.reg_v[0];
          nxt_s.reg_we = 1'b1;
        end
        OP_ADD_WITH_CARRY_RR: begin
          // register doubled plus carry: bit 3 out, carry in at bit 0
          nxt_s.reg_res = sum[NIB_W-1:0];
          nxt_s.reg_v = sum[NIB_W-1:0];
          nxt_s.cy = sum[NIB_W];
          if (sum[NIB_W-1:0] != NIB_RST) begin
            nxt_s.zf = 1'b0;
          end
          nxt_s.reg_we = 1'b1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_ff.ack <= 1'b0;
      s_ff.wreq <= 1'b1;
      s_ff.rdata <= RD_RST;
      s_ff.op <= OP_OR_RM;
      s_ff.reg_v <= NIB_RST;
      s_ff.mem_v <= NIB_RST;
      s_ff.imm_v <= NIB_RST;
      s_ff.idx_en <= PSW_FLAG_RST;
      s_ff.zf <= PSW_FLAG_RST;
      s_ff.cy <= PSW_FLAG_RST;
      s_ff.cmpf <= PSW_FLAG_RST;
      s_ff.bcd <= PSW_FLAG_RST;
      s_ff.maddr <= MADR_RST;
      s_ff.ix <= MADR_RST;
      s_ff.reg_res <= NIB_RST;
      s_ff.mem_res <= NIB_RST;
      s_ff.reg_we <= 1'b0;
      s_ff.mem_we <= 1'b0;
      s_ff.skip <= 1'b0;
      s_ff.supp <= 1'b0;
      s_ff.eaddr <= MADR_RST;
    end else if (ce_in) begin
      s_ff <= nxt_s;
    end
  end

  assign avs_readdata_out = s_ff.rdata;
  assign avs_waitrequest_out = s_ff.wreq;
  assign reg_res_out = s_ff.reg_res;
  assign mem_res_out = s_ff.mem_res;
  assign reg_wr_out = s_ff.reg_we;
  assign mem_wr_out = s_ff.mem_we;
  assign skip_out = s_ff.skip;
  assign eaddr_out = s_ff.eaddr;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);

  logic run;
  assign run = ce_in & go;

  a_or_result: assert property (
    run && op == OP_OR_RM |=>
      reg_res_out == ($past(s_ff.reg_v) | $past(s_ff.mem_v)) && reg_wr_out
  ) else $error("or result wrong");

  a_and_result: assert property (
    run && op == OP_AND_MI |=>
      mem_res_out == ($past(s_ff.mem_v) & $past(s_ff.imm_v)) && mem_wr_out
  ) else $error("and result wrong");

  a_xor_mem_wb: assert property (
    run && op == OP_XOR_MI |=>
      mem_wr_out && !reg_wr_out
      && mem_res_out == ($past(s_ff.mem_v) ^ $past(s_ff.imm_v))
  ) else $error("xor write-back wrong");

  a_bit_test_flags: assert property (
    run && (op == OP_SKIP_BITS_TRUE || op == OP_SKIP_BITS_FALSE) |=>
      !s_ff.cmpf && $stable(s_ff.cy) && $stable(s_ff.zf)
  ) else $error("bit test flag effect wrong");

  a_bits_true_skip: assert property (
    run && op == OP_SKIP_BITS_TRUE |=>
      skip_out == (($past(s_ff.mem_v) & $past(s_ff.imm_v)) == $past(s_ff.imm_v))
  ) else $error("bits true skip wrong");

  a_bits_false_skip: assert property (
    run && op == OP_SKIP_BITS_FALSE |=>
      skip_out == (($past(s_ff.mem_v) & $past(s_ff.imm_v)) == NIB_RST)
  ) else $error("bits false skip wrong");

  a_less_skip: assert property (
    run && op == OP_SKIP_LESS |=>
      skip_out == ($past(s_ff.mem_v) < $past(s_ff.imm_v)) && $stable(s_ff.cy)
  ) else $error("less skip wrong");

  a_rotate_right: assert property (
    run && op == OP_ROTATE_RIGHT_CARRY |=>
      reg_res_out == {$past(s_ff.cy), $past(s_ff.reg_v[NIB_W-1:1])}
      && s_ff.cy == $past(s_ff.reg_v[0]) && $stable(s_ff.zf)
  ) else $error("rotate right wrong");

  a_index_addr: assert property (
    run && s_ff.idx_en && op == OP_SKIP_BITS_TRUE |=>
      eaddr_out == ($past(s_ff.maddr) | $past(s_ff.ix))
  ) else $error("indexed address wrong");

  a_skip_suppress: assert property (
    ce_in && exec && s_ff.skip |=>
      !reg_wr_out && !mem_wr_out && !skip_out && s_ff.supp
      && $stable(s_ff.cy) && $stable(s_ff.reg_v) && $stable(s_ff.mem_v)
  ) else $error("suppressed op had effect");

  a_bus_answer: assert property (
    ce_in && req && avs_waitrequest_out |=> !avs_waitrequest_out
  ) else $error("waitrequest not released");

  a_xor_reg_result: assert property (
    run && op == OP_XOR_RM |=>
      reg_res_out == ($past(s_ff.reg_v) ^ $past(s_ff.mem_v)) && reg_wr_out && !mem_wr_out
  ) else $error("xor result wrong");

  a_equal_skip: assert property (
    run && op == OP_SKIP_EQUAL |=> skip_out == (($past(s_ff.mem_v) ^ $past(s_ff.imm_v)) == NIB_RST)
  ) else $error("equal skip wrong");

  a_unequal_skip: assert property (
    run && op == OP_SKIP_NOT_EQUAL |=> skip_out == ($past(s_ff.mem_v) != $past(s_ff.imm_v))
  ) else $error("unequal skip wrong");

  a_at_least_skip: assert property (
    run && op == OP_SKIP_GREATER_EQUAL |=>
      skip_out == !($past(s_ff.mem_v) < $past(s_ff.imm_v))
  ) else $error("greater-equal skip wrong");

  a_compare_flags: assert property (
    run && op inside {OP_SKIP_EQUAL, OP_SKIP_NOT_EQUAL, OP_SKIP_GREATER_EQUAL,
      OP_SKIP_LESS} |=>
      $stable(s_ff.cy) && $stable(s_ff.zf) && $stable(s_ff.cmpf) && !reg_wr_out && !mem_wr_out
  ) else $error("compare skip touched flags");

  a_logic_flags: assert property (
    run && op inside {OP_OR_RM, OP_AND_RM, OP_XOR_RM, OP_OR_MI, OP_AND_MI, OP_XOR_MI} |=>
      $stable(s_ff.cy) && $stable(s_ff.zf) && $stable(s_ff.cmpf) && $stable(s_ff.bcd)
  ) else $error("logic op touched flags");

  a_rotate_flags: assert property (
    run && op == OP_ROTATE_RIGHT_CARRY |=>
      reg_wr_out && !mem_wr_out && $stable(s_ff.cmpf) && $stable(s_ff.mem_v)
  ) else $error("rotate touched more than register and carry");

  a_left_rotate: assert property (
    run && op == OP_ADD_WITH_CARRY_RR |=>
      reg_res_out == {$past(s_ff.reg_v[NIB_W-2:0]), $past(s_ff.cy)}
      && s_ff.cy == $past(s_ff.reg_v[NIB_W-1])
  ) else $error("left rotate through carry wrong");

  a_bit_test_mode: assert property (
    run && (op == OP_SKIP_BITS_TRUE || op == OP_SKIP_BITS_FALSE) |=>
      $stable(s_ff.bcd) && !reg_wr_out && !mem_wr_out
  ) else $error("bit test side effect");

  c_skip_taken: cover property (run && op == OP_SKIP_EQUAL ##1 skip_out);
  c_suppressed: cover property (ce_in && exec && s_ff.skip);
  c_rotate: cover property (run && op == OP_ROTATE_RIGHT_CARRY);
  c_left_rot: cover property (run && op == OP_ADD_WITH_CARRY_RR && s_ff.cy);
  c_bits_false: cover property (run && op == OP_SKIP_BITS_FALSE ##1 skip_out);
endmodule
`default_nettype wire

/* File: nibble_alu_pkg.sv */
// constants, opcodes and register map of the nibble logic/skip/rotate unit
package nibble_alu_pkg;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned MADR_W = 11;
  localparam int unsigned AV_AW = 5;
  localparam int unsigned AV_DW = 32;
  // register byte offsets
  localparam logic [AV_AW-1:0] OFS_CMD = 5'h00;
  localparam logic [AV_AW-1:0] OFS_OPND = 5'h04;
  localparam logic [AV_AW-1:0] OFS_PSW = 5'h08;
  localparam logic [AV_AW-1:0] OFS_ADDR = 5'h0c;
  localparam logic [AV_AW-1:0] OFS_RES = 5'h10;
  // operand register fields
  localparam int unsigned OPND_REG_LSB = 0;
  localparam int unsigned OPND_MEM_LSB = 4;
  localparam int unsigned OPND_IMM_LSB = 8;
  // program status word bits
  localparam int unsigned PSW_IDX_EN = 0;
  localparam int unsigned PSW_ZF = 1;
  localparam int unsigned PSW_CY = 2;
  localparam int unsigned PSW_CMP = 3;
  localparam int unsigned PSW_BCD = 4;
  // address register fields
  localparam int unsigned ADDR_MEM_LSB = 0;
  localparam int unsigned ADDR_IX_LSB = 16;
  // reset values
  localparam logic [NIB_W-1:0] NIB_RST = 4'h0;
  localparam logic [MADR_W-1:0] MADR_RST = 11'h000;
  localparam logic [AV_DW-1:0] RD_RST = 32'h0000_0000;
  localparam logic PSW_FLAG_RST = 1'b0;
  typedef enum logic [NIB_W-1:0] {
    OP_OR_RM = 4'h0,
    OP_AND_RM = 4'h1,
    OP_XOR_RM = 4'h2,
    OP_OR_MI = 4'h3,
    OP_AND_MI = 4'h4,
    OP_XOR_MI = 4'h5,
    OP_SKIP_BITS_TRUE = 4'h6,
    OP_SKIP_BITS_FALSE = 4'h7,
    OP_SKIP_EQUAL = 4'h8,
    OP_SKIP_NOT_EQUAL = 4'h9,
    OP_SKIP_GREATER_EQUAL = 4'ha,
    OP_SKIP_LESS = 4'hb,
    OP_ROTATE_RIGHT_CARRY = 4'hc,
    OP_ADD_WITH_CARRY_RR = 4'hd
  } op_t;
endpackage

/* File: test_nibble_alu.sv */
// self-checking testbench of the nibble logic, skip and rotate unit
`timescale 1ns/1ps
`default_nettype none
module test_nibble_alu;
  import nibble_alu_pkg::*;
  // opnd holds opcode, register, memory and immediate nibbles; fl is skip, reg write, mem write
  typedef struct packed {
    logic [15:0] opnd;
    logic [4:0] p;
    logic [4:0] ep;
    logic [3:0] res;
    logic [2:0] fl;
  } row_t;
  row_t rows[$];
  logic core_clk_in;
  logic rstn_in;
  logic ce_in;
  logic [AV_AW-1:0] avs_address_in;
  logic avs_read_in;
  logic avs_write_in;
  logic [AV_DW-1:0] avs_writedata_in;
  logic [AV_DW-1:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [NIB_W-1:0] reg_res_out;
  logic [NIB_W-1:0] mem_res_out;
  logic reg_wr_out;
  logic mem_wr_out;
  logic skip_out;
  logic [MADR_W-1:0] eaddr_out;
  logic [31:0] q;
  int num_errors;
  int cmp_count;

  nibble_alu nibble_alu_i (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .reg_res_out(reg_res_out), .mem_res_out(mem_res_out), .reg_wr_out(reg_wr_out),
    .mem_wr_out(mem_wr_out), .skip_out(skip_out), .eaddr_out(eaddr_out)
  );

  always #2.5 core_clk_in = ~core_clk_in;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held up to the edge that finds waitrequest low, released right after it
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    do begin
      @(posedge core_clk_in);
    end while (avs_waitrequest_out !== 1'h0);
    q = avs_readdata_out;
    avs_write_in <= 1'h0;
    avs_read_in <= 1'h0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    check(q, exp);
  endtask

  // sequencer outputs land on the accepting edge, so look half a cycle later
  task automatic cmd(input logic [3:0] op, input logic [2:0] fl);
    bus(1'h1, OFS_CMD, {28'h0, op});
    @(negedge core_clk_in);
    check({skip_out, reg_wr_out, mem_wr_out}, fl);
  endtask

  task automatic give_verdict();
    $display("errors %0d, comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_in);
    num_errors++;
    give_verdict();
  end

  initial begin
    core_clk_in = 1'h0;
    rstn_in = 1'h0;
    ce_in = 1'h1;
    avs_address_in = 5'h00;
    avs_read_in = 1'h0;
    avs_write_in = 1'h0;
    avs_writedata_in = 32'h0;
    num_errors = 0;
    cmp_count = 0;
    rows.push_back('{16'h0a90, 5'h1e, 5'h1e, 4'hb, 3'h2});
    rows.push_back('{16'h1a90, 5'h1e, 5'h1e, 4'h8, 3'h2});
    rows.push_back('{16'h2a90, 5'h1e, 5'h1e, 4'h3, 3'h2});
    rows.push_back('{16'h309c, 5'h1e, 5'h1e, 4'hd, 3'h1});
    rows.push_back('{16'h409c, 5'h1e, 5'h1e, 4'h8, 3'h1});
    rows.push_back('{16'h509c, 5'h1e, 5'h1e, 4'h5, 3'h1});
    rows.push_back('{16'h60bb, 5'h1e, 5'h16, 4'h0, 3'h4});
    rows.push_back('{16'h60bd, 5'h1e, 5'h16, 4'h0, 3'h0});
    rows.push_back('{16'h7096, 5'h1e, 5'h16, 4'h0, 3'h4});
    rows.push_back('{16'h709e, 5'h1e, 5'h16, 4'h0, 3'h0});
    rows.push_back('{16'h80aa, 5'h1e, 5'h1e, 4'h0, 3'h4});
    rows.push_back('{16'h80a8, 5'h1e, 5'h1e, 4'h0, 3'h0});
    rows.push_back('{16'h90a8, 5'h1e, 5'h1e, 4'h0, 3'h4});
    rows.push_back('{16'h90aa, 5'h1e, 5'h1e, 4'h0, 3'h0});
    rows.push_back('{16'ha087, 5'h1e, 5'h1e, 4'h0, 3'h4});
    rows.push_back('{16'ha088, 5'h1e, 5'h1e, 4'h0, 3'h4});
    rows.push_back('{16'ha089, 5'h1e, 5'h1e, 4'h0, 3'h0});
    rows.push_back('{16'ha0f0, 5'h1e, 5'h1e, 4'h0, 3'h4});
    rows.push_back('{16'hb089, 5'h1e, 5'h1e, 4'h0, 3'h4});
    rows.push_back('{16'hb088, 5'h1e, 5'h1e, 4'h0, 3'h0});
    rows.push_back('{16'hb087, 5'h1e, 5'h1e, 4'h0, 3'h0});
    rows.push_back('{16'hb00f, 5'h1e, 5'h1e, 4'h0, 3'h4});
    rows.push_back('{16'hc900, 5'h1e, 5'h1e, 4'hc, 3'h2});
    rows.push_back('{16'hc800, 5'h1a, 5'h1a, 4'h4, 3'h2});
    rows.push_back('{16'hc100, 5'h0a, 5'h0e, 4'h0, 3'h2});
    rows.push_back('{16'hd900, 5'h04, 5'h04, 4'h3, 3'h2});
    repeat (4) @(posedge core_clk_in);
    @(negedge core_clk_in);
    check({avs_waitrequest_out, reg_res_out, mem_res_out, reg_wr_out, mem_wr_out, skip_out,
           eaddr_out}, {1'h1, 22'h0});
    check(avs_readdata_out, 32'h0);
    @(posedge core_clk_in);
    rstn_in <= 1'h1;
    rd(OFS_PSW, 32'h0);
    rd(OFS_OPND, 32'h0);
    rd(OFS_ADDR, 32'h0);
    rd(OFS_RES, 32'h0);
    rd(5'h14, 32'h0);
    bus(1'h1, OFS_ADDR, 32'h0404_0123);
    foreach (rows[k]) begin
      bus(1'h1, OFS_PSW, {27'h0, rows[k].p});
      bus(1'h1, OFS_OPND, {20'h0, rows[k].opnd[3:0], rows[k].opnd[7:4], rows[k].opnd[11:8]});
      cmd(rows[k].opnd[15:12], rows[k].fl);
      rd(OFS_PSW, {27'h0, rows[k].ep});
      if (rows[k].fl[1]) begin
        check(reg_res_out, rows[k].res);
      end
      if (rows[k].fl[0]) begin
        check(mem_res_out, rows[k].res);
      end
      check(eaddr_out, 11'h123);
      cmd(4'he, 3'h0);
    end
    // a taken skip must swallow the next command whole
    bus(1'h1, OFS_PSW, 32'h0);
    bus(1'h1, OFS_OPND, 32'h0000_0552);
    cmd(OP_SKIP_EQUAL, 3'h4);
    cmd(OP_OR_RM, 3'h0);
    bus(1'h0, OFS_RES, 32'h0);
    check(q[9:8], 2'h2);
    rd(OFS_OPND, 32'h0000_0552);
    rd(OFS_PSW, 32'h0);
    // index enabled: address is or-ed with the index register
    bus(1'h1, OFS_PSW, 32'h1);
    bus(1'h1, OFS_OPND, 32'h0000_01f0);
    cmd(OP_SKIP_BITS_TRUE, 3'h4);
    check(eaddr_out, 11'h527);
    cmd(4'hf, 3'h0);
    // chained rotates rely on the register write-back
    bus(1'h1, OFS_PSW, 32'h4);
    bus(1'h1, OFS_OPND, 32'h0000_0009);
    cmd(OP_ROTATE_RIGHT_CARRY, 3'h2);
    cmd(OP_ROTATE_RIGHT_CARRY, 3'h2);
    check(reg_res_out, 4'he);
    rd(OFS_PSW, 32'h0);
    cmd(OP_ADD_WITH_CARRY_RR, 3'h2);
    check(reg_res_out, 4'hc);
    rd(OFS_PSW, 32'h4);
    check(eaddr_out, 11'h527);
    // enable low must stall a pending access until it rises again
    ce_in <= 1'h0;
    fork
      rd(OFS_PSW, 32'h4);
      begin
        repeat (3) @(posedge core_clk_in);
        check(avs_waitrequest_out, 1'h1);
        check(reg_res_out, 4'hc);
        ce_in <= 1'h1;
      end
    join
    // reset in mid-run clears results and flags again
    rstn_in <= 1'h0;
    @(negedge core_clk_in);
    check({avs_waitrequest_out, reg_res_out, eaddr_out}, {1'h1, 15'h0});
    @(posedge core_clk_in);
    rstn_in <= 1'h1;
    rd(OFS_PSW, 32'h0);
    rd(OFS_OPND, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
